/* stws_pkg.sv */
/*
  stws_pkg: constants shared by the transmit word type selector and its testbench.
  Assumes a single 10 MHz REF_CLK domain and a word-wide AHB-Lite register port.
*/
package stws_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int REF_CLK_PERIOD_NS = 100;
  localparam int LATENCY_TENTHS    = 14;  // word clock cycles x10
  localparam int FIRST_BIT_CYCLES  = (LATENCY_TENTHS + 9) / 10;

  // ---------------------------------------------------------------
  // word and frame layout
  // ---------------------------------------------------------------
  localparam int WORD_BITS   = 16;
  localparam int CTRL_BITS   = 14;
  localparam int FRAME_BITS  = 20;
  localparam int ENTRY_BITS  = 18;
  localparam int ENT_FLAG    = 16;
  localparam int ENT_TYPE    = 17;
  localparam int FRAME_FLAG  = 16;
  localparam logic [3:0]  HDR_CTRL     = 4'h5;
  localparam logic [3:0]  HDR_IDLE     = 4'h3;
  localparam logic [2:0]  HDR_DATA_TOP = 3'h6;
  localparam logic [15:0] IDLE_PAYLOAD = 16'h00ff;
  localparam logic [6:0]  LFSR_SEED    = 7'h7f;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_STATUS   = 8'h04;
  localparam logic [7:0] A_DATA_CNT = 8'h08;
  localparam logic [7:0] A_CTRL_CNT = 8'h0c;
  localparam logic [7:0] A_IDLE_CNT = 8'h10;

  localparam int CTRL_FLAG_EXT = 0;
  localparam int CTRL_SCRAMBLE = 1;
  localparam int CTRL_EXT_CLK  = 2;
  localparam logic [2:0] CTRL_RESET = 3'h2;

  localparam int ST_INT_FLAG = 0;
  localparam int ST_FULL     = 1;
  localparam int ST_EMPTY    = 2;
  localparam int ST_OVERRUN  = 3;

  typedef enum logic [0:0] {
    ST_WAIT = 1'b0,
    ST_SEND = 1'b1
  } stws_state_e;

endpackage

/* stws_fifo.sv */
/*
  stws_fifo: small valid/ready buffer between the sampled word inputs and the serialiser.
  Assumes one clock and an asynchronous active-low reset; full and empty are flops.
*/
`timescale 1ns/10ps
module stws_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("stws_fifo depth must be a power of two, at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             full;
  logic             empty;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [PW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & ~full;
  assign pop       = out_ready & ~empty;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      full   <= 1'b0;
      empty  <= 1'b1;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      full   <= (next_count == (PW+1)'(DEPTH));
      empty  <= (next_count == '0);
    end
  end

  // memory holds data only, so it needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule // stws_fifo

/* stws_top.sv */
/*
  stws_top: transmit word type selection, flag handling and serial framing.
  Assumes word inputs arrive asynchronously on pins, registers over AHB-Lite, one clock.
*/
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
module stws_top #(
  parameter int SLOW_DIV = 4
) (
  input  wire logic        REF_CLK,
  input  wire logic        RESETN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic [31:0]      HRDATA,
  output logic             HRESP,
  input  wire logic [15:0] WORD_IN,
  input  wire logic        EXTRA_FLAG_IN,
  input  wire logic        DATA_WORD_REQUEST,
  input  wire logic        CONTROL_WORD_REQUEST,
  output logic             WORD_READY,
  output logic             SERIAL_LINE_OUT_P,
  output logic             SERIAL_LINE_OUT_N
);

  if (SLOW_DIV < 2 || SLOW_DIV > 255) begin : g_bad_div
    $error("stws_top SLOW_DIV must lie in 2..255");
  end

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  // all inputs move as one vector so word, flag and requests stay paired
  logic [18:0] sync1;
  logic [18:0] sync2;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {CONTROL_WORD_REQUEST, DATA_WORD_REQUEST, EXTRA_FLAG_IN, WORD_IN};
      sync2 <= sync1;
    end
  end

  // ---------------------------------------------------------------
  // word type select and buffer
  // ---------------------------------------------------------------
  logic                                 push_valid;
  logic [stws_pkg::ENTRY_BITS-1:0]      push_data;
  logic                                 fifo_in_ready;
  logic                                 fifo_out_valid;
  logic                                 fifo_pop;
  logic [stws_pkg::ENTRY_BITS-1:0]      fifo_out;

  assign push_valid = sync2[18] | sync2[17];
  // control request wins; the flag bit is kept only for data words
  assign push_data  = {sync2[18], sync2[16] & ~sync2[18], sync2[15:0]};

  stws_fifo #(
    .WIDTH (stws_pkg::ENTRY_BITS),
    .DEPTH (2)
  ) u_fifo (
    .clk       (REF_CLK),
    .rst_n     (RESETN),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out)
  );
  assign WORD_READY = fifo_in_ready;

  // ---------------------------------------------------------------
  // register file state
  // ---------------------------------------------------------------
  logic [2:0]  ctrl;
  logic        overrun;
  logic [15:0] data_cnt;
  logic [15:0] ctrl_cnt;
  logic [15:0] idle_cnt;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        addr_ph;
  logic [2:0]  next_ctrl;
  logic        next_overrun;
  logic [31:0] next_hrdata;

  assign addr_ph = HSEL & HTRANS[1] & HREADY;

  // ---------------------------------------------------------------
  // serialiser state
  // ---------------------------------------------------------------
  stws_pkg::stws_state_e            state;
  stws_pkg::stws_state_e            next_state;
  logic [stws_pkg::FRAME_BITS-1:0]  shreg;
  logic [stws_pkg::FRAME_BITS-1:0]  next_shreg;
  logic [4:0]                       bit_idx;
  logic [4:0]                       next_bit_idx;
  logic [7:0]                       div_cnt;
  logic [7:0]                       next_div_cnt;
  logic                             int_flag;
  logic                             next_int_flag;
  logic [6:0]                       lfsr;
  logic [6:0]                       next_lfsr;
  logic                             bit_stage;
  logic                             strobe;
  logic                             load;
  logic                             flag_sel;
  logic                             flag_coded;
  logic                             ld_data;
  logic                             ld_ctrl;
  logic                             ld_idle;

  // the word clock can stand in for the bit clock only at a slower bit rate
  assign strobe  = ctrl[stws_pkg::CTRL_EXT_CLK] ? (div_cnt == 8'(SLOW_DIV - 1)) : 1'b1;
  assign load    = strobe & ((state == stws_pkg::ST_WAIT) ||
                             (bit_idx == 5'(stws_pkg::FRAME_BITS - 1)));
  assign fifo_pop = load & fifo_out_valid;
  assign ld_ctrl = fifo_pop & fifo_out[stws_pkg::ENT_TYPE];
  assign ld_data = fifo_pop & ~fifo_out[stws_pkg::ENT_TYPE];
  assign ld_idle = load & ~fifo_out_valid;
  assign flag_sel = ctrl[stws_pkg::CTRL_FLAG_EXT] ? fifo_out[stws_pkg::ENT_FLAG]
                                                  : int_flag;
  assign flag_coded = flag_sel ^ (ctrl[stws_pkg::CTRL_SCRAMBLE] & lfsr[0]);

  always_comb begin
    next_state    = state;
    next_shreg    = shreg;
    next_bit_idx  = bit_idx;
    next_int_flag = int_flag;
    next_lfsr     = lfsr;
    next_div_cnt  = (strobe || !ctrl[stws_pkg::CTRL_EXT_CLK]) ? 8'h00 : div_cnt + 8'h01;
    if (load) begin
      next_state   = stws_pkg::ST_SEND;
      next_bit_idx = 5'h00;
      if (ld_ctrl) begin
        next_shreg = {stws_pkg::HDR_CTRL, 2'b00, fifo_out[stws_pkg::CTRL_BITS-1:0]};
      end else if (ld_data) begin
        next_shreg    = {stws_pkg::HDR_DATA_TOP, flag_coded, fifo_out[15:0]};
        next_int_flag = ~int_flag;
        next_lfsr     = {lfsr[5:0], lfsr[6] ^ lfsr[5]};
      end else begin
        next_shreg = {stws_pkg::HDR_IDLE, stws_pkg::IDLE_PAYLOAD};
      end
    end else if (strobe) begin
      next_shreg   = {1'b0, shreg[stws_pkg::FRAME_BITS-1:1]};
      next_bit_idx = bit_idx + 5'h01;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state             <= stws_pkg::ST_WAIT;
      shreg             <= '0;
      bit_idx           <= '0;
      int_flag          <= 1'b0;
      lfsr              <= stws_pkg::LFSR_SEED;
      div_cnt           <= '0;
      bit_stage         <= 1'b0;
      SERIAL_LINE_OUT_P <= 1'b0;
      SERIAL_LINE_OUT_N <= 1'b1;
    end else begin
      state             <= next_state;
      shreg             <= next_shreg;
      bit_idx           <= next_bit_idx;
      int_flag          <= next_int_flag;
      lfsr              <= next_lfsr;
      div_cnt           <= next_div_cnt;
      // two stages after the load edge give the rounded-up first-bit latency
      bit_stage         <= shreg[0];
      SERIAL_LINE_OUT_P <= bit_stage;
      SERIAL_LINE_OUT_N <= ~bit_stage;
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  always_comb begin
    next_ctrl    = ctrl;
    next_overrun = overrun;
    if (wr_pend && wr_addr == stws_pkg::A_CTRL) begin
      next_ctrl = HWDATA[2:0];
    end
    if (wr_pend && wr_addr == stws_pkg::A_STATUS && HWDATA[stws_pkg::ST_OVERRUN]) begin
      next_overrun = 1'b0;
    end
    // a word lost in the same cycle as the clear keeps the flag set
    if (push_valid && !fifo_in_ready) begin
      next_overrun = 1'b1;
    end
    next_hrdata = 32'h0000_0000;
    if (addr_ph && !HWRITE) begin
      case (HADDR[7:0])
        stws_pkg::A_CTRL:     next_hrdata = {29'h0, ctrl};
        stws_pkg::A_STATUS:   next_hrdata = {28'h0, overrun, ~fifo_out_valid,
                                             ~fifo_in_ready, int_flag};
        stws_pkg::A_DATA_CNT: next_hrdata = {16'h0, data_cnt};
        stws_pkg::A_CTRL_CNT: next_hrdata = {16'h0, ctrl_cnt};
        stws_pkg::A_IDLE_CNT: next_hrdata = {16'h0, idle_cnt};
        default:              next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl      <= stws_pkg::CTRL_RESET;
      overrun   <= 1'b0;
      data_cnt  <= '0;
      ctrl_cnt  <= '0;
      idle_cnt  <= '0;
      wr_pend   <= 1'b0;
      wr_addr   <= '0;
      HRDATA    <= '0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      overrun   <= next_overrun;
      data_cnt  <= data_cnt + {15'h0, ld_data};
      ctrl_cnt  <= ctrl_cnt + {15'h0, ld_ctrl};
      idle_cnt  <= idle_cnt + {15'h0, ld_idle};
      wr_pend   <= addr_ph & HWRITE;
      wr_addr   <= HADDR[7:0];
      HRDATA    <= next_hrdata;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  a_sample_together: assert property (push_valid == ($past(DATA_WORD_REQUEST, 2) |
      $past(CONTROL_WORD_REQUEST, 2))) else $error("request not sampled with word");
  a_ctrl_wins: assert property (sync2[18] && sync2[17] |-> push_data[stws_pkg::ENT_TYPE]
      && !push_data[stws_pkg::ENT_FLAG]) else $error("data request beat control");
  a_ctrl_frame: assert property (ld_ctrl |=> shreg[19:14] == {stws_pkg::HDR_CTRL, 2'b00}
      && shreg[13:0] == $past(fifo_out[13:0])) else $error("control frame malformed");
  a_data_payload: assert property (ld_data |=> shreg[15:0] == $past(fifo_out[15:0])
      && shreg[19:17] == stws_pkg::HDR_DATA_TOP) else $error("data payload wrong");
  a_ext_flag: assert property (ld_data && ctrl[stws_pkg::CTRL_FLAG_EXT] |=>
      shreg[stws_pkg::FRAME_FLAG] == ($past(fifo_out[stws_pkg::ENT_FLAG]) ^
      ($past(ctrl[stws_pkg::CTRL_SCRAMBLE]) & $past(lfsr[0]))))
      else $error("extended flag not carried");
  a_int_flag_alt: assert property (ld_data && !ctrl[stws_pkg::CTRL_FLAG_EXT] &&
      !ctrl[stws_pkg::CTRL_SCRAMBLE] |=> shreg[stws_pkg::FRAME_FLAG] == $past(int_flag)
      && int_flag != $past(int_flag)) else $error("internal flag not alternating");
  a_scramble_step: assert property (ld_data |=> lfsr != $past(lfsr))
      else $error("scrambler did not advance");
  a_idle_frame: assert property (ld_idle |=> shreg == {stws_pkg::HDR_IDLE,
      stws_pkg::IDLE_PAYLOAD}) else $error("idle word not sent");
  a_first_bit: assert property (load |=> ##2 SERIAL_LINE_OUT_P == $past(shreg[0], 2)
      && SERIAL_LINE_OUT_N != SERIAL_LINE_OUT_P) else $error("first bit late");
  a_clock_select: assert property ((!ctrl[stws_pkg::CTRL_EXT_CLK] |-> strobe) and
      (ctrl[stws_pkg::CTRL_EXT_CLK] && strobe |=> !strobe)) else $error("bit rate wrong");

  c_data_sent: cover property (ld_data ##20 ld_data);
  c_ctrl_sent: cover property (ld_ctrl);
  c_idle_sent: cover property (ld_idle);
  c_buffer_full: cover property (!fifo_in_ready && push_valid);

endmodule // stws_top

/* stws_rx_model.sv */
/*
  stws_rx_model: far-end receiver model that cuts the serial line back into frames.
  Assumes one bit per REF_CLK (external serial clock off) and idle frames after reset.
*/
`timescale 1ns/10ps
module stws_rx_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic line_p,
  input  wire logic line_n,
  input  wire logic rx_flag_extend_enable,
  input  wire logic rx_flag_scramble_enable,
  output logic      rx_flag,
  output int        pol_err
);
  // ---------------------------------------------------------------
  // deframing
  // ---------------------------------------------------------------
  logic [19:0] frames[$];
  logic [19:0] sr;
  logic [19:0] win;
  logic        locked;
  int          cnt;

  // idle frames are dropped; the bench only waits for traffic
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr      <= 20'h00000;
      locked  <= 1'b0;
      cnt     <= 0;
      pol_err <= 0;
      rx_flag <= 1'b0;
    end else begin
      win = {line_p, sr[19:1]};
      sr <= win;
      if (line_n !== ~line_p) begin
        pol_err <= pol_err + 1;
      end
      // idle pattern is unique under rotation, so it gives the frame phase
      if (!locked) begin
        locked <= (win === 20'h300ff);
        cnt    <= 0;
      end else if (cnt == 19) begin
        cnt <= 0;
        if (win !== 20'h300ff) begin
          frames.push_back(win);
          rx_flag <= rx_flag_extend_enable & win[16];
        end
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule // stws_rx_model

/* stws_top_tb_top.sv */
/*
  stws_top_tb_top: self-checking bench for the transmit word type selector.
  Assumes a 10 MHz REF_CLK, zero-wait AHB-Lite and the far-end model on the serial pair.
*/
`timescale 1ns/10ps
module stws_top_tb_top;
  // ---------------------------------------------------------------
  // stimulus and wiring
  // ---------------------------------------------------------------
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [15:0] word_in = 16'h0000;
  logic        flag_in = 1'b0;
  logic        dreq = 1'b0;
  logic        creq = 1'b0;
  logic        hready;
  logic [31:0] hrdata;
  logic        word_ready;
  logic        p;
  logic        n;
  logic [19:0] fr;
  logic [31:0] rd;
  logic [31:0] rd2;
  int          fail_count = 0;
  int          checked = 0;
  int          cyc = 0;
  int          pol_err;

  always #50 ref_clk = ~ref_clk;

  stws_top u_stws_top (
    .REF_CLK(ref_clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(), .WORD_IN(word_in),
    .EXTRA_FLAG_IN(flag_in), .DATA_WORD_REQUEST(dreq), .CONTROL_WORD_REQUEST(creq),
    .WORD_READY(word_ready), .SERIAL_LINE_OUT_P(p), .SERIAL_LINE_OUT_N(n));

  stws_rx_model u_stws_rx_model (
    .clk(ref_clk), .rst_n(resetn), .line_p(p), .line_n(n), .rx_flag_extend_enable(1'b1),
    .rx_flag_scramble_enable(1'b1), .rx_flag(), .pol_err(pol_err));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (exp !== got) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  // zero-wait slave: hready is still polled, the timeout ends a hang
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    d = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    ahb(1'b1, a, wd, d);
  endtask

  // one request cycle, then wait for the matching frame at the far end
  task automatic send(input logic d, input logic c, input logic [15:0] w, input logic f);
    int k;
    dreq    <= d;
    creq    <= c;
    word_in <= w;
    flag_in <= f;
    @(posedge ref_clk);
    dreq <= 1'b0;
    creq <= 1'b0;
    for (k = 0; k < 200 && u_stws_rx_model.frames.size() == 0; k++) @(posedge ref_clk);
    fr = (k < 200) ? u_stws_rx_model.frames.pop_front() : 20'hxxxxx;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    ahb(1'b0, stws_pkg::A_CTRL, 32'h0, rd);
    chk("ctrl reset", 32'h00000002, rd);
    ahb(1'b0, 8'h14, 32'h0, rd);
    chk("unmapped", 32'h00000000, rd);
    ahb(1'b0, stws_pkg::A_IDLE_CNT, 32'h0, rd);
    repeat (97) @(posedge ref_clk);
    ahb(1'b0, stws_pkg::A_IDLE_CNT, 32'h0, rd2);
    chk("idle words", 32'h5, rd2 - rd);
  endtask

  task automatic t_data_ext();
    wr(stws_pkg::A_CTRL, 32'h1);
    send(1'b1, 1'b0, 16'ha5c3, 1'b1);
    chk("data flag 1", {12'h0, 20'hda5c3}, {12'h0, fr});
    send(1'b1, 1'b0, 16'h3c5a, 1'b0);
    chk("data flag 0", {12'h0, 20'hc3c5a}, {12'h0, fr});
  endtask

  task automatic t_ctrl();
    send(1'b0, 1'b1, 16'hffff, 1'b1);
    chk("control", {12'h0, 20'h53fff}, {12'h0, fr});
    send(1'b1, 1'b1, 16'h8123, 1'b1);
    chk("both requests", {12'h0, 20'h50123}, {12'h0, fr});
  endtask

  task automatic t_int_flag();
    logic f0;
    wr(stws_pkg::A_CTRL, 32'h0);
    send(1'b1, 1'b0, 16'h1111, 1'b1);
    f0 = fr[16];
    chk("int word", {12'h0, 4'hc, 16'h1111}, {12'h0, fr[19:17], 1'b0, fr[15:0]});
    send(1'b1, 1'b0, 16'h2222, 1'b1);
    chk("int flag alt", {31'h0, ~f0}, {31'h0, fr[16]});
  endtask

  task automatic t_scramble();
    logic any;
    any = 1'b0;
    wr(stws_pkg::A_CTRL, 32'h3);
    for (int i = 0; i < 8; i++) begin
      send(1'b1, 1'b0, 16'h0f0f, 1'b0);
      any |= fr[16];
      chk("scr word", {12'h0, 4'hc, 16'h0f0f}, {12'h0, fr[19:17], 1'b0, fr[15:0]});
    end
    chk("scr flag", 32'h1, {31'h0, any});
    ahb(1'b0, stws_pkg::A_DATA_CNT, 32'h0, rd);
    chk("data count", 32'd12, rd);
    ahb(1'b0, stws_pkg::A_CTRL_CNT, 32'h0, rd);
    chk("ctrl count", 32'd2, rd);
  endtask

  // back-to-back requests overrun the two-entry buffer, then it drains
  task automatic t_buffer();
    logic low;
    low = 1'b0;
    dreq <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      word_in <= 16'h0100 + i[15:0];
      @(posedge ref_clk);
      low |= (word_ready === 1'b0);
    end
    dreq <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("ready dropped", 32'h1, {31'h0, low});
    ahb(1'b0, stws_pkg::A_STATUS, 32'h0, rd);
    chk("overrun", 32'h1, {31'h0, rd[stws_pkg::ST_OVERRUN]});
    wr(stws_pkg::A_STATUS, 32'h8);
    repeat (100) @(posedge ref_clk);
    ahb(1'b0, stws_pkg::A_STATUS, 32'h0, rd);
    chk("drained", 32'h4, {28'h0, rd[3:0]} & 32'he);
    chk("line polarity", 32'h0, pol_err);
  endtask

  // slow bit rate from the word clock; the far-end model cannot follow it, so this runs last
  task automatic t_ext_clk();
    wr(stws_pkg::A_CTRL, 32'h6);
    ahb(1'b0, stws_pkg::A_CTRL, 32'h0, rd);
    chk("ctrl ext clk", 32'h00000006, rd);
    repeat (100) @(posedge ref_clk);
    ahb(1'b0, stws_pkg::A_IDLE_CNT, 32'h0, rd);
    repeat (158) @(posedge ref_clk);
    ahb(1'b0, stws_pkg::A_IDLE_CNT, 32'h0, rd2);
    // 160 cycles between captures hold two frames of 20 bits at 4 cycles a bit
    chk("slow idle words", 32'h2, rd2 - rd);
  endtask

  // ---------------------------------------------------------------
  // sequence and timeout
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (60) @(posedge ref_clk);
    t_regs();
    t_data_ext();
    t_ctrl();
    t_int_flag();
    t_scramble();
    t_buffer();
    t_ext_clk();
    print_verdict();
  end
endmodule // stws_top_tb_top
